// ---- verilog/osfpp_port.sv ----
/*
  Device end of a serial flash host port: select, serial clock, eight
  two-way lanes and a returned read strobe. Captures host bytes into a
  system-clock stream and launches read bytes from a system-clock stream.
  Assumes the host runs clock mode 0 (clock idles low) and keeps the
  lane and rate settings stable around and during each frame.
*/
// Notes on behaviour
// - lanes and read strobe float whenever the device is not driving.
// - select high deselects, enters standby not deep sleep, floats outputs.
// - while deselected, nothing on the input lane is accepted.
// - a self-timed operation ended by deselect finishes before standby.
// - single-edge modes capture command, address and data on rising edges.
// - single-edge modes launch read data on falling serial clock edges.
// - quad and octal double-edge modes capture address and data on both clock edges.
// - command bytes use rising edges only, a full clock per transfer.
// - quad uses lanes 3 to 0, octal 7 to 0 with lane zero two-way.
// - serial clock returns as read strobe synchronous with read data.
// - quad and octal double-edge modes drive read data on both serial clock edges.
`default_nettype none
`timescale 1ns/1ps

module osfpp_port #(
  parameter int FIFO_AW = osfpp_pkg::FIFO_AW
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     sck,
  input  wire logic                     cs_n,
  input  wire logic [7:0]               lane_in,
  output logic [7:0]                    lane_out,
  output logic [7:0]                    lane_oe_n,
  output logic                          read_strobe_out,
  output logic                          read_strobe_oe_n,
  input  wire osfpp_pkg::osfpp_cfg_type cfg_in,
  input  wire logic                     busy,
  output logic                          rx_valid,
  output osfpp_pkg::osfpp_item_type     rx_item,
  input  wire logic                     rx_ready,
  input  wire logic                     tx_valid,
  input  wire osfpp_pkg::osfpp_item_type tx_item,
  output logic                          tx_ready,
  output logic                          selected,
  output logic                          standby,
  output logic                          frame_end
);

  // -------------------------------------------------------------------
  // system clock side
  // -------------------------------------------------------------------
  logic                    cs_s1_r, cs_s2_r, cs_prev_r;
  logic                    link_rst_n_r, standby_r, standby_nxt;
  logic                    frame_end_r, frame_end_nxt;
  osfpp_pkg::osfpp_cfg_type cfg_r, cfg_nxt;

  // config follows the input only while deselected, so it is frozen
  // for the whole frame and the link side may read it directly
  always_comb begin
    cfg_nxt       = cs_s2_r ? cfg_in : cfg_r;
    standby_nxt   = cs_s2_r && !busy;
    frame_end_nxt = cs_s2_r && !cs_prev_r;  // select rising seen
  end

  // select synchroniser, config and status registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_s1_r      <= 1'b1;
      cs_s2_r      <= 1'b1;
      cs_prev_r    <= 1'b1;
      cfg_r        <= osfpp_pkg::CFG_RESET;
      link_rst_n_r <= 1'b0;
      standby_r    <= 1'b0;
      frame_end_r  <= 1'b0;
    end else begin
      cs_s1_r      <= cs_n;
      cs_s2_r      <= cs_s1_r;
      cs_prev_r    <= cs_s2_r;
      cfg_r        <= cfg_nxt;
      link_rst_n_r <= 1'b1;
      standby_r    <= standby_nxt;
      frame_end_r  <= frame_end_nxt;
    end
  end

  assign selected  = ~cs_prev_r;
  assign standby   = standby_r;
  assign frame_end = frame_end_r;

  // -------------------------------------------------------------------
  // link side: shared decode
  // -------------------------------------------------------------------
  logic       sck_n;
  logic       ddr;
  logic [4:0] w, n;
  logic       cmd_done_r, cmd_done_nxt, drive_r, drive_nxt;

  assign sck_n = ~sck;
  assign w     = osfpp_pkg::lane_bits(cfg_r.lanes);
  // double-edge only after the command byte, never on a single lane
  assign ddr   = (cfg_r.rate == osfpp_pkg::double_edge_rate) &&
                 (cfg_r.lanes != osfpp_pkg::lanes_single) &&
                 cmd_done_r;
  assign n     = ddr ? 5'(w << 1) : w;

  // input lanes right-aligned for the current mode
  function automatic logic [15:0] pick(input logic [7:0] l);
    unique case (cfg_r.lanes)
      osfpp_pkg::quad_lane_mode: pick = {12'h000, l[3:0]};
      osfpp_pkg::lanes_octal:    pick = {8'h00, l};
      default:                   pick = {15'h0000, l[0]};
    endcase
  endfunction

  // top bits of a launch word spread onto the lanes of the mode
  function automatic logic [7:0] place(input logic [15:0] sh);
    logic [7:0] b;
    b = 8'(sh >> (osfpp_pkg::PAIR_BITS - w));
    unique case (cfg_r.lanes)
      osfpp_pkg::quad_lane_mode: place = {4'h0, b[3:0]};
      osfpp_pkg::lanes_octal:    place = b;
      default:                   place = {6'h00, b[0], 1'b0};
    endcase
  endfunction

  // -------------------------------------------------------------------
  // link side: rising edge capture and launch
  // -------------------------------------------------------------------
  logic [7:0] rise_lanes_r, out_rise_r, out_rise_pend_r;

  // select high clears everything, so a deselected port takes nothing
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rise_lanes_r <= '0;
      out_rise_r   <= '0;
    end else begin
      rise_lanes_r <= lane_in;
      out_rise_r   <= out_rise_pend_r;
    end
  end

  // -------------------------------------------------------------------
  // link side: falling edge assembly and launch
  // -------------------------------------------------------------------
  logic [15:0]              rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt;
  logic [4:0]               rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
  logic [7:0]               out_fall_r, out_fall_nxt, out_rise_pend_nxt;
  logic [15:0]              cap, sh;
  logic [4:0]               cnt, sum;
  logic                     launch, rx_push;
  logic                     tx_pop, tx_r_valid;
  osfpp_pkg::osfpp_item_type rx_w_item, tx_r_item;

  always_comb begin
    rx_sh_nxt         = rx_sh_r;
    rx_cnt_nxt        = rx_cnt_r;
    tx_sh_nxt         = tx_sh_r;
    tx_cnt_nxt        = tx_cnt_r;
    out_fall_nxt      = out_fall_r;
    out_rise_pend_nxt = out_rise_pend_r;
    cmd_done_nxt      = cmd_done_r;
    drive_nxt         = drive_r;
    rx_push           = 1'b0;
    rx_w_item         = '0;
    tx_pop            = 1'b0;
    sh                = tx_sh_r;
    cnt               = tx_cnt_r;
    sum               = 5'(rx_cnt_r + n);
    // rising sample, plus the falling sample in double-edge data
    cap = ddr ? ((pick(rise_lanes_r) << w) | pick(lane_in))
              : pick(rise_lanes_r);
    launch = drive_r || (cmd_done_r && tx_r_valid);
    if (!launch) begin
      rx_sh_nxt  = 16'(rx_sh_r << n) | cap;
      rx_cnt_nxt = sum;
      // no push while deselected, even if the clock runs
      if (!cs_n && sum >= osfpp_pkg::BYTE_BITS) begin
        rx_push        = 1'b1;
        rx_w_item.cmd  = ~cmd_done_r;
        rx_w_item.pair = sum == osfpp_pkg::PAIR_BITS;
        // a lone byte drops the earlier byte left in the upper half
        rx_w_item.data = rx_w_item.pair ? rx_sh_nxt
                                        : {8'h00, rx_sh_nxt[7:0]};
        rx_cnt_nxt     = '0;
        cmd_done_nxt   = 1'b1;
      end
    end else begin
      drive_nxt = 1'b1;
      // refill when the launch word is spent; underrun holds the lanes
      if (cnt == '0 && tx_r_valid) begin
        tx_pop = 1'b1;
        sh     = tx_r_item.pair ? tx_r_item.data
                                : {tx_r_item.data[7:0], 8'h00};
        cnt    = tx_r_item.pair ? osfpp_pkg::PAIR_BITS
                                : osfpp_pkg::BYTE_BITS;
      end
      if (cnt >= n) begin
        out_fall_nxt      = place(sh);
        out_rise_pend_nxt = place(16'(sh << w));
        sh                = 16'(sh << n);
        cnt               = 5'(cnt - n);
      end
      tx_sh_nxt  = sh;
      tx_cnt_nxt = cnt;
    end
  end

  // falling edge state; select high ends the frame at once
  always_ff @(posedge sck_n or posedge cs_n) begin
    if (cs_n) begin
      rx_sh_r         <= '0;
      rx_cnt_r        <= '0;
      tx_sh_r         <= '0;
      tx_cnt_r        <= '0;
      out_fall_r      <= '0;
      out_rise_pend_r <= '0;
      cmd_done_r      <= 1'b0;
      drive_r         <= 1'b0;
    end else begin
      rx_sh_r         <= rx_sh_nxt;
      rx_cnt_r        <= rx_cnt_nxt;
      tx_sh_r         <= tx_sh_nxt;
      tx_cnt_r        <= tx_cnt_nxt;
      out_fall_r      <= out_fall_nxt;
      out_rise_pend_r <= out_rise_pend_nxt;
      cmd_done_r      <= cmd_done_nxt;
      drive_r         <= drive_nxt;
    end
  end

  // -------------------------------------------------------------------
  // pins
  // -------------------------------------------------------------------
  // in double-edge data, after a rising edge the rising half shows, else the falling half
  assign lane_out  = (ddr && sck) ? out_rise_r : out_fall_r;
  assign lane_oe_n = drive_r ? ~osfpp_pkg::lane_mask(cfg_r.lanes)
                             : osfpp_pkg::LANES_OFF;
  assign read_strobe_out  = drive_r & sck;
  assign read_strobe_oe_n = ~drive_r;

  // -------------------------------------------------------------------
  // domain crossings
  // -------------------------------------------------------------------
  osfpp_cdc_fifo #(
    .W  ($bits(osfpp_pkg::osfpp_item_type)),
    .AW (FIFO_AW)
  ) u_rx_fifo (
    .wclk    (sck_n),
    .wrst_n  (link_rst_n_r),
    .w_valid (rx_push),
    .w_data  (rx_w_item),
    .w_ready (),
    .rclk    (mclk),
    .rrst_n  (rst_n),
    .r_valid (rx_valid),
    .r_data  (rx_item),
    .r_ready (rx_ready)
  );

  osfpp_cdc_fifo #(
    .W  ($bits(osfpp_pkg::osfpp_item_type)),
    .AW (FIFO_AW)
  ) u_tx_fifo (
    .wclk    (mclk),
    .wrst_n  (rst_n),
    .w_valid (tx_valid),
    .w_data  (tx_item),
    .w_ready (tx_ready),
    .rclk    (sck_n),
    .rrst_n  (link_rst_n_r),
    .r_valid (tx_r_valid),
    .r_data  (tx_r_item),
    .r_ready (tx_pop)
  );

endmodule // osfpp_port

`default_nettype wire

// ---- verilog/osfpp_pkg.sv ----
/*
  Shared types and constants for the serial flash host port: lane modes,
  edge rates, the captured/launched item carrier and lane helpers.
  Assumes nothing of its surroundings; included by compile order only.
*/
`default_nettype none

package osfpp_pkg;

  // -------------------------------------------------------------------
  // modes
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    lanes_single,
    quad_lane_mode,
    lanes_octal
  } osfpp_lanes_type;

  typedef enum logic {
    single_edge_rate,
    double_edge_rate
  } osfpp_rate_type;

  typedef struct packed {
    osfpp_lanes_type lanes;
    osfpp_rate_type  rate;
  } osfpp_cfg_type;

  // one captured or launched unit: a byte, or a byte pair
  typedef struct packed {
    logic        cmd;   // first byte of a frame
    logic        pair;  // data holds two bytes, upper one first
    logic [15:0] data;  // single byte sits in the low eight bits
  } osfpp_item_type;

  // -------------------------------------------------------------------
  // constants
  // -------------------------------------------------------------------
  localparam osfpp_cfg_type CFG_RESET = '{lanes_single, single_edge_rate};
  localparam logic [4:0] BYTE_BITS   = 5'h08;
  localparam logic [4:0] PAIR_BITS   = 5'h10;
  localparam logic [4:0] BITS_SINGLE = 5'h01;
  localparam logic [4:0] BITS_QUAD   = 5'h04;
  localparam logic [4:0] BITS_OCTAL  = 5'h08;
  localparam logic [7:0] MASK_SINGLE = 8'h02;  // serial output is lane 1
  localparam logic [7:0] MASK_QUAD   = 8'h0f;
  localparam logic [7:0] MASK_OCTAL  = 8'hff;
  localparam logic [7:0] LANES_OFF   = 8'hff;
  localparam int         FIFO_AW     = 2;

  // -------------------------------------------------------------------
  // lane helpers
  // -------------------------------------------------------------------
  // bits moved per clock edge
  function automatic logic [4:0] lane_bits(input osfpp_lanes_type m);
    unique case (m)
      quad_lane_mode: lane_bits = BITS_QUAD;
      lanes_octal:    lane_bits = BITS_OCTAL;
      default:        lane_bits = BITS_SINGLE;
    endcase
  endfunction

  // lanes that this mode drives
  function automatic logic [7:0] lane_mask(input osfpp_lanes_type m);
    unique case (m)
      quad_lane_mode: lane_mask = MASK_QUAD;
      lanes_octal:    lane_mask = MASK_OCTAL;
      default:        lane_mask = MASK_SINGLE;
    endcase
  endfunction

endpackage

`default_nettype wire

// ---- verilog/osfpp_cdc_fifo.sv ----
/*
  Small dual-clock FIFO with gray-coded pointers, used to carry items
  between the serial clock domain and the system clock domain.
  Assumes each side's reset is a constant-only asynchronous clear, and
  that the write clock may stop between frames.
*/
`default_nettype none
`timescale 1ns/1ps

module osfpp_cdc_fifo #(
  parameter int W  = 18,
  parameter int AW = 2
) (
  input  wire logic         wclk,
  input  wire logic         wrst_n,
  input  wire logic         w_valid,
  input  wire logic [W-1:0] w_data,
  output logic              w_ready,
  input  wire logic         rclk,
  input  wire logic         rrst_n,
  output logic              r_valid,
  output logic [W-1:0]      r_data,
  input  wire logic         r_ready
);

  // -------------------------------------------------------------------
  // storage and pointers
  // -------------------------------------------------------------------
  logic [W-1:0] mem [1<<AW];
  logic [AW:0]  wbin_r, wbin_nxt, wgray_r, rg_s1_r, rg_s2_r;
  logic [AW:0]  rbin_r, rbin_nxt, rgray_r, wg_s1_r, wg_s2_r;
  logic         full;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // full when the gray pointers differ in the top two bits only
  assign full    = wgray_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
  assign w_ready = ~full;
  assign r_valid = rgray_r != wg_s2_r;
  assign r_data  = mem[rbin_r[AW-1:0]];

  // pointer advance
  always_comb begin
    wbin_nxt = wbin_r + (AW+1)'(w_valid & ~full);
    rbin_nxt = rbin_r + (AW+1)'(r_ready & r_valid);
  end

  // -------------------------------------------------------------------
  // write side
  // -------------------------------------------------------------------
  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_r  <= '0;
      wgray_r <= '0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end else begin
      wbin_r  <= wbin_nxt;
      wgray_r <= to_gray(wbin_nxt);
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  // storage write
  always_ff @(posedge wclk) begin
    if (w_valid && !full) begin
      mem[wbin_r[AW-1:0]] <= w_data;
    end
  end

  // -------------------------------------------------------------------
  // read side
  // -------------------------------------------------------------------
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_r  <= '0;
      rgray_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      rbin_r  <= rbin_nxt;
      rgray_r <= to_gray(rbin_nxt);
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
    end
  end

endmodule // osfpp_cdc_fifo

`default_nettype wire

// ---- tb/osfpp_port_props.sv ----
/*
  Pin checker for osfpp_port, bound onto every instance.
  Assumes mclk runs free and rst_n is synchronous, active low.
*/
`default_nettype none
`timescale 1ns/1ps
module osfpp_port_props (
  input wire logic                     mclk,
  input wire logic                     rst_n,
  input wire logic                     sck,
  input wire logic                     cs_n,
  input wire logic [7:0]               lane_oe_n,
  input wire logic                     read_strobe_out,
  input wire logic                     read_strobe_oe_n,
  input wire osfpp_pkg::osfpp_cfg_type cfg_in,
  input wire logic                     busy,
  input wire logic                     selected,
  input wire logic                     standby,
  input wire logic                     frame_end
);
  // ---------------------------------------------------------------
  // pin, mode and select checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic drv;
  // any lane driven by the device
  assign drv = (lane_oe_n != 8'hff);
  property p_float; cs_n |-> !drv && read_strobe_oe_n; endproperty
  a_float: assert property (p_float) else $error("pins driven");
  property p_strobe; !read_strobe_oe_n |-> read_strobe_out == sck;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe");
  property p_quiet; read_strobe_oe_n |-> !read_strobe_out; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe idle");
  property p_pair; drv |-> !read_strobe_oe_n; endproperty
  a_pair: assert property (p_pair) else $error("no strobe");
  property p_single;
    drv && cfg_in.lanes == osfpp_pkg::lanes_single |-> lane_oe_n == 8'hfd;
  endproperty
  a_single: assert property (p_single) else $error("single lanes");
  property p_quad;
    drv && cfg_in.lanes == osfpp_pkg::quad_lane_mode |-> lane_oe_n == 8'hf0;
  endproperty
  a_quad: assert property (p_quad) else $error("quad lanes");
  property p_octal;
    drv && cfg_in.lanes == osfpp_pkg::lanes_octal |-> lane_oe_n == 8'h00;
  endproperty
  a_octal: assert property (p_octal) else $error("octal lanes");
  property p_busy; busy [*3] |-> !standby; endproperty
  a_busy: assert property (p_busy) else $error("standby busy");
  property p_sel; selected |-> !standby; endproperty
  a_sel: assert property (p_sel) else $error("standby sel");
  property p_start; $fell(cs_n) |-> ##[1:5] selected; endproperty
  a_start: assert property (p_start) else $error("no select");
  property p_end; $rose(cs_n) |-> ##[1:5] frame_end; endproperty
  a_end: assert property (p_end) else $error("no frame end");
  // main scenarios reached
  c_drive: cover property (!read_strobe_oe_n);
  c_end: cover property (frame_end);
  c_busy: cover property (busy && cs_n ##1 !busy);
endmodule // osfpp_port_props

bind osfpp_port osfpp_port_props osfpp_port_props_i (
  .mclk, .rst_n, .sck, .cs_n, .lane_oe_n, .read_strobe_out,
  .read_strobe_oe_n, .cfg_in, .busy, .selected, .standby, .frame_end
);
`default_nettype wire

// ---- tb/osfpp_host.sv ----
/*
  Behavioural host controller: select, 6 ns serial clock within frames,
  lane drive and strobe-qualified read capture.
  Assumes the bench resolves lanes with pull-downs.
*/
`default_nettype none
`timescale 1ns/1ps
module osfpp_host (
  output logic            cs_n,
  output logic            sck,
  output logic [7:0]      host_out,
  output logic [7:0]      host_oe,
  input  wire logic [7:0] lane_w,
  input  wire logic       strobe_w
);
  // ---------------------------------------------------------------
  // link driving
  // ---------------------------------------------------------------
  logic [7:0] rq[$];
  // idle: deselected, clock still
  initial begin
    cs_n = 1'h1;
    sck = 1'h0;
    host_out = 8'h00;
    host_oe = 8'h00;
  end
  // half cycle, capture pre-edge lanes on strobe edge
  task automatic edge_to(input logic lvl, input logic cap);
    logic [7:0] v;
    logic s;
    #1.5;
    v = lane_w;
    s = strobe_w;
    sck = lvl;
    #0.5;
    if (cap && (lvl ? strobe_w : s)) rq.push_back(v);
    #1.0;
  endtask
  task automatic frame(input logic [1:0] md, input logic ddr,
                       input logic [23:0] wr, input int nw, input int nrd);
    int w;
    logic [7:0] b;
    logic lvl;
    w = (md == 2'h2) ? 8 : (md == 2'h1) ? 4 : 1;
    lvl = 1'h0;
    rq.delete();
    #4;
    cs_n = 1'h0;
    host_oe = 8'((1 << w) - 1);
    #150;
    for (int i = 0; i < nw; i++) begin
      b = wr[23 - 8 * i -: 8];
      for (int k = 0; k < 8; k += w) begin
        host_out = 8'((b << k) >> (8 - w)); // msb first
        if (ddr && i > 0) begin
          lvl = !lvl;
          edge_to(lvl, 1'h0);
        end else begin
          edge_to(1'h1, 1'h0);
          edge_to(1'h0, 1'h0);
        end
      end
    end
    if (lvl) edge_to(1'h0, 1'h0);
    host_oe = 8'h00;
    repeat (nrd) begin
      edge_to(1'h1, 1'h1);
      edge_to(1'h0, ddr);
    end
    #150;
    cs_n = 1'h1;
    #150;
  endtask
  // lanes and clock toggle while deselected
  task automatic noise();
    host_oe = 8'hff;
    repeat (20) begin
      host_out = ~host_out;
      sck = ~sck;
      #20;
    end
    host_oe = 8'h00;
  endtask
endmodule // osfpp_host
`default_nettype wire

// ---- tb/osfpp_port_tb.sv ----
/*
  Self-checking bench for osfpp_port with a host model on the link.
  Assumes the checker is bound separately.
*/
`default_nettype none
`timescale 1ns/1ps
module osfpp_port_tb;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic                      mclk, rst_n, busy, rx_ready, tx_valid;
  logic                      cs_n, sck, rx_valid, tx_ready;
  logic                      read_strobe_out, read_strobe_oe_n;
  logic                      selected, standby, frame_end;
  logic [7:0]                lane_out, lane_oe_n, host_out, host_oe;
  osfpp_pkg::osfpp_cfg_type  cfg_in;
  osfpp_pkg::osfpp_item_type tx_item, rx_item;
  osfpp_pkg::osfpp_item_type rxq[$];
  int                        err_total, n_compared;
  wire logic [7:0]           lane_w;
  wire logic                 strobe_w;
  // undriven lanes pulled down
  assign lane_w = (~lane_oe_n & lane_out) |
                  (lane_oe_n & host_oe & host_out);
  assign strobe_w = !read_strobe_oe_n & read_strobe_out;
  osfpp_port osfpp_port_i (
    .mclk, .rst_n, .sck, .cs_n, .lane_in(lane_w), .lane_out, .lane_oe_n,
    .read_strobe_out, .read_strobe_oe_n, .cfg_in, .busy, .rx_valid,
    .rx_item, .rx_ready, .tx_valid, .tx_item, .tx_ready, .selected,
    .standby, .frame_end
  );
  osfpp_host osfpp_host_i (
    .cs_n, .sck, .host_out, .host_oe, .lane_w, .strobe_w
  );
  // clock and captured items
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (rx_valid === 1'h1) rxq.push_back(rx_item);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [17:0] ex,
                     input logic [17:0] got);
    n_compared++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic setcfg(input osfpp_pkg::osfpp_lanes_type l,
                        input osfpp_pkg::osfpp_rate_type r);
    @(posedge mclk) cfg_in <= '{l, r};
    wc(6);
    rxq.delete();
  endtask
  task automatic tx_push(input logic [15:0] d, input logic pr);
    @(posedge mclk);
    tx_valid <= 1'h1;
    tx_item <= '{1'h0, pr, d};
    @(posedge mclk);
    while (tx_ready !== 1'h1) @(posedge mclk);
    tx_valid <= 1'h0;
    wc(4);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_idle();
    wc(8);
    chk("lane_oe_n", 18'h000ff, 18'(lane_oe_n));
    chk("strobe_oe_n", 18'h1, 18'(read_strobe_oe_n));
    chk("standby", 18'h1, 18'(standby));
    chk("selected", 18'h0, 18'(selected));
    $display("t_idle done");
  endtask
  task automatic t_desel();
    rxq.delete();
    osfpp_host_i.noise();
    wc(6);
    chk("rx idle", 18'h0, 18'(rxq.size()));
    $display("t_desel done");
  endtask
  task automatic t_single();
    logic [7:0] b;
    setcfg(osfpp_pkg::lanes_single, osfpp_pkg::single_edge_rate);
    busy <= 1'h1;
    osfpp_host_i.frame(2'h0, 1'h0, 24'h5a3c00, 2, 0);
    wc(6);
    chk("rx count", 18'h2, 18'(rxq.size()));
    chk("rx cmd", {1'h1, 1'h0, 16'h005a}, rxq[0]);
    chk("rx data", {1'h0, 1'h0, 16'h003c}, rxq[1]);
    chk("standby busy", 18'h0, 18'(standby));
    busy <= 1'h0;
    wc(6);
    chk("standby", 18'h1, 18'(standby));
    tx_push(16'h0096, 1'h0);
    osfpp_host_i.frame(2'h0, 1'h0, 24'h0b0000, 1, 9);
    b = 8'h00;
    for (int i = 0; i < 8; i++) b = {b[6:0], osfpp_host_i.rq[i][1]};
    chk("rd serial", 18'h96, 18'(b));
    $display("t_single done");
  endtask
  task automatic t_quad();
    setcfg(osfpp_pkg::quad_lane_mode, osfpp_pkg::single_edge_rate);
    tx_push(16'h00a5, 1'h0);
    osfpp_host_i.frame(2'h1, 1'h0, 24'h9b0000, 1, 6);
    wc(6);
    chk("rx cmd", {1'h1, 1'h0, 16'h009b}, rxq[0]);
    chk("rd0", 18'h0a, 18'(osfpp_host_i.rq[0] & 8'h0f));
    chk("rd1", 18'h05, 18'(osfpp_host_i.rq[1] & 8'h0f));
    $display("t_quad done");
  endtask
  task automatic t_octal();
    setcfg(osfpp_pkg::lanes_octal, osfpp_pkg::double_edge_rate);
    osfpp_host_i.frame(2'h2, 1'h1, 24'hc31234, 3, 0);
    wc(6);
    chk("rx count", 18'h2, 18'(rxq.size()));
    chk("rx cmd", {1'h1, 1'h0, 16'h00c3}, rxq[0]);
    chk("rx pair", {1'h0, 1'h1, 16'h1234}, rxq[1]);
    tx_push(16'hbeef, 1'h1);
    osfpp_host_i.frame(2'h2, 1'h1, 24'h0f0000, 1, 4);
    chk("rd0", 18'hbe, 18'(osfpp_host_i.rq[0]));
    chk("rd1", 18'hef, 18'(osfpp_host_i.rq[1]));
    $display("t_octal done");
  endtask
  // main sequence
  initial begin
    rst_n = 1'h0;
    busy = 1'h0;
    rx_ready = 1'h1;
    tx_valid = 1'h0;
    tx_item = '0;
    cfg_in = osfpp_pkg::CFG_RESET;
    err_total = 0;
    n_compared = 0;
    wc(16);
    rst_n <= 1'h1;
    wc(2);
    t_idle();
    t_desel();
    t_single();
    t_quad();
    t_octal();
    stop_test();
  end
  // watchdog
  initial begin
    #60000;
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    stop_test();
  end
endmodule // osfpp_port_tb
`default_nettype wire
